// file: pkg/usa_ab_if.sv
// Control and event signals between the register side and the rate counter.
`timescale 1ns/1ps
interface usa_ab_if;
   logic start_req;
   logic stop_req;
   logic mode;
   logic rearm;
   logic busy;
   logic done;
   logic timeout;

   modport ctrl (output start_req, output stop_req, output mode, output rearm,
      input busy, input done, input timeout);
   modport meas (input start_req, input stop_req, input mode, input rearm,
      output busy, output done, output timeout);
endinterface

// file: pkg/usa_params.svh
// Address map, bit positions and reset values of the status and auto-baud block.
`ifndef USA_PARAMS_SVH
`define USA_PARAMS_SVH

// ------------------------------------------------------------
// Register addresses
// ------------------------------------------------------------
`define USA_ADDR_LSR 32'he000c014
`define USA_ADDR_SCR 32'he000c01c
`define USA_ADDR_ACR 32'he000c020

// ------------------------------------------------------------
// Line status bit positions
// ------------------------------------------------------------
`define USA_LSR_LOW_MSB 4
`define USA_LSR_HOLDING_EMPTY_FLAG 5
`define USA_LSR_TRANSMITTER_IDLE_FLAG 6
`define USA_LSR_RX_FIFO_ERROR_FLAG 7

// ------------------------------------------------------------
// Auto-baud control bit positions
// ------------------------------------------------------------
`define USA_ACR_START 0
`define USA_ACR_MODE 1
`define USA_ACR_REARM 2
`define USA_ACR_DONE_CLR 8
`define USA_ACR_TO_CLR 9

// ------------------------------------------------------------
// Reset values and widths
// ------------------------------------------------------------
`define USA_SCR_RST 8'h00
`define USA_HOLDING_EMPTY_FLAG_RST 1'b1
`define USA_TRANSMITTER_IDLE_FLAG_RST 1'b1
`define USA_RX_FIFO_ERROR_FLAG_RST 1'b0
`define USA_RX_IDLE 1'b1
`define USA_CNT_W 16

`endif

// file: pkg/usa_pkg.sv
// Types shared by the status and auto-baud block.
package usa_pkg;

   // Auto-baud measurement sequencer states.
   typedef enum logic [1:0] {
      USA_IDLE,
      USA_WAIT_FALL,
      USA_COUNT,
      USA_DONE
   } usa_ab_state_t;

   // Upper line status flags.
   typedef struct packed {
      logic holding_empty;
      logic tx_idle;
      logic rx_err;
   } usa_flags_t;

   // Register side state of the top module.
   typedef struct packed {
      logic [7:0] scratch;
      logic mode;
      logic rearm;
      logic start_req;
      logic stop_req;
      logic done_pend;
      logic to_pend;
      logic [31:0] rdata;
   } usa_ctrl_t;

endpackage

// file: rtl/usa_autobaud.sv
// Auto-baud rate measurement counter and its sequencer.
`timescale 1ns/1ps
`include "usa_params.svh"
module usa_autobaud import usa_pkg::*; #(
   parameter int CNT_W = `USA_CNT_W
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic ce,
   input wire logic rx_line,
   usa_ab_if.meas ab,
   output logic divisor_load,
   output logic [CNT_W-1:0] divisor_value
);

   typedef struct packed {
      usa_ab_state_t state;
      logic rx_q;
      logic [CNT_W-1:0] cnt;
      logic load;
      logic [CNT_W-1:0] div;
      logic done;
      logic timeout;
   } usa_ab_q_t;

   usa_ab_q_t q;
   usa_ab_q_t next_q;
   logic fall;
   logic rise;
   logic stop_edge;

   // Edges of the receive line against its value one clock earlier.
   assign fall = q.rx_q & ~rx_line;
   assign rise = ~q.rx_q & rx_line;
   assign stop_edge = ab.mode ? rise : fall;

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   // A full counter is the time-out; the count never wraps to a wrong rate.
   always_comb begin
      next_q = q;
      next_q.rx_q = rx_line;
      next_q.load = 1'b0;
      next_q.done = 1'b0;
      next_q.timeout = 1'b0;
      case (q.state)
         USA_IDLE: begin
            if (ab.start_req) begin
               next_q.cnt = '0;
               next_q.state = USA_WAIT_FALL;
            end
         end
         USA_WAIT_FALL: begin
            if (fall) begin
               next_q.cnt = '0;
               next_q.state = USA_COUNT;
            end
         end
         USA_COUNT: begin
            if (stop_edge) begin
               next_q.div = q.cnt;
               next_q.load = 1'b1;
               next_q.state = USA_DONE;
            end else if (&q.cnt) begin
               next_q.timeout = 1'b1;
               next_q.state = ab.rearm ? USA_WAIT_FALL : USA_IDLE;
            end else begin
               next_q.cnt = q.cnt + 1'b1;
            end
         end
         USA_DONE: begin
            next_q.done = 1'b1;
            next_q.state = USA_IDLE;
         end
         default: begin
            next_q.state = USA_IDLE;
         end
      endcase
      if (ab.stop_req && q.state != USA_IDLE) begin
         next_q.state = USA_IDLE;
         next_q.load = 1'b0;
      end
   end

   // State register; a low clock enable freezes it.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         q <= '{state: USA_IDLE, rx_q: `USA_RX_IDLE, default: '0};
      end else if (ce) begin
         q <= next_q;
      end
   end

   assign ab.busy = (q.state != USA_IDLE);
   assign ab.done = q.done;
   assign ab.timeout = q.timeout;
   assign divisor_load = q.load;
   assign divisor_value = q.div;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   sequence s_edge_hit;
      ce && q.state == USA_COUNT && stop_edge && !ab.stop_req;
   endsequence
   sequence s_load_then_done;
      (divisor_load && !ab.done) ##1 (ab.done && !divisor_load);
   endsequence

   done_order_a: assert property (s_edge_hit ##1 ce |-> s_load_then_done)
      else $error("divisor load and done event out of order");
   timeout_a: assert property (ce && q.state == USA_COUNT && &q.cnt && !stop_edge
      && !ab.stop_req |=> ab.timeout
      && q.state == ($past(ab.rearm) ? USA_WAIT_FALL : USA_IDLE))
      else $error("counter overflow without time-out");
   rearm_a: assert property (ce && q.state == USA_WAIT_FALL && fall && !ab.stop_req
      |=> q.state == USA_COUNT && q.cnt == '0)
      else $error("measurement not restarted on falling edge");

endmodule // usa_autobaud

// file: rtl/usa_line_flags.sv
// Holding-empty, transmitter-idle and receive-error flags of the line status.
`timescale 1ns/1ps
`include "usa_params.svh"
module usa_line_flags import usa_pkg::*; (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic ce,
   input wire logic thr_write,
   input wire logic thr_drained,
   input wire logic tsr_busy,
   input wire logic rx_err_load,
   input wire logic rx_err_pending,
   input wire logic fifo_en,
   input wire logic lsr_read,
   output logic holding_empty_flag,
   output logic transmitter_idle_flag,
   output logic rx_fifo_error_flag
);

   usa_flags_t q;
   usa_flags_t next_q;

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   // Set terms win over write and read clears, but a disabled fifo clears the error flag even on an error load.
   always_comb begin
      next_q = q;
      if (thr_drained) begin
         next_q.holding_empty = 1'b1;
      end else if (thr_write) begin
         next_q.holding_empty = 1'b0;
      end
      next_q.tx_idle = next_q.holding_empty & ~tsr_busy;
      if (!fifo_en) begin
         next_q.rx_err = 1'b0;
      end else if (rx_err_load) begin
         next_q.rx_err = 1'b1;
      end else if (lsr_read && !rx_err_pending) begin
         next_q.rx_err = 1'b0;
      end
   end

   // State register; a low clock enable freezes it.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         q <= '{holding_empty: `USA_HOLDING_EMPTY_FLAG_RST, tx_idle: `USA_TRANSMITTER_IDLE_FLAG_RST, rx_err: `USA_RX_FIFO_ERROR_FLAG_RST};
      end else if (ce) begin
         q <= next_q;
      end
   end

   assign holding_empty_flag = q.holding_empty;
   assign transmitter_idle_flag = q.tx_idle;
   assign rx_fifo_error_flag = q.rx_err;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   holding_empty_flag_set_a: assert property (ce && thr_drained |=> holding_empty_flag)
      else $error("holding empty flag not set after drain");
   holding_empty_flag_clear_a: assert property (ce && thr_write && !thr_drained |=> !holding_empty_flag)
      else $error("holding empty flag not cleared by write");
   transmitter_idle_flag_busy_a: assert property (ce && tsr_busy |=> !transmitter_idle_flag)
      else $error("transmitter idle while shift register busy");
   rx_fifo_error_flag_set_a: assert property (ce && fifo_en && rx_err_load |=> rx_fifo_error_flag)
      else $error("receive error flag not set on error load");
   rx_fifo_error_flag_clear_a: assert property (ce && fifo_en && lsr_read && !rx_err_pending && !rx_err_load
      |=> !rx_fifo_error_flag)
      else $error("receive error flag not cleared by status read");
   rx_fifo_error_flag_off_a: assert property (ce && !fifo_en |=> !rx_fifo_error_flag)
      else $error("receive error flag set with fifo disabled");

endmodule // usa_line_flags

// file: rtl/usa_status_autobaud.sv
// Line status upper flags, scratch byte and auto-baud control register.
`timescale 1ns/1ps
`include "usa_params.svh"

module usa_status_autobaud import usa_pkg::*; #(
   parameter int CNT_W = `USA_CNT_W
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic ce,
   input wire logic [31:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_wdata,
   output logic [31:0] reg_rdata,
   input wire logic [4:0] lsr_low_bits,
   input wire logic thr_write,
   input wire logic thr_drained,
   input wire logic tsr_busy,
   input wire logic rx_err_load,
   input wire logic rx_err_pending,
   input wire logic fifo_en,
   input wire logic rx_line,
   input wire logic done_irq_en,
   input wire logic timeout_irq_en,
   output logic holding_empty_flag,
   output logic transmitter_idle_flag,
   output logic rx_fifo_error_flag,
   output logic divisor_load,
   output logic [CNT_W-1:0] divisor_value,
   output logic baud_done_irq,
   output logic baud_timeout_irq
);

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   usa_ctrl_t q;
   usa_ctrl_t next_q;
   usa_ab_if ab ();
   logic sel_lsr;
   logic sel_scr;
   logic sel_acr;
   logic wr_scr;
   logic wr_acr;
   logic lsr_read;
   logic [7:0] line_status_reg;
   logic [31:0] acr_view;

   // Address decode of the three registers of this block.
   assign sel_lsr = (reg_addr == `USA_ADDR_LSR);
   assign sel_scr = (reg_addr == `USA_ADDR_SCR);
   assign sel_acr = (reg_addr == `USA_ADDR_ACR);
   assign wr_scr = reg_wr & sel_scr;
   assign wr_acr = reg_wr & sel_acr;

   // A status read is what clears the receive error flag, so it is decoded
   // here and handed to the flag logic in the same cycle.
   assign lsr_read = reg_rd & sel_lsr & ce;

   // ------------------------------------------------------------
   // Line status flags
   // ------------------------------------------------------------
   usa_line_flags u_flags (
      .clk(clk),
      .reset_n(reset_n),
      .ce(ce),
      .thr_write(thr_write),
      .thr_drained(thr_drained),
      .tsr_busy(tsr_busy),
      .rx_err_load(rx_err_load),
      .rx_err_pending(rx_err_pending),
      .fifo_en(fifo_en),
      .lsr_read(lsr_read),
      .holding_empty_flag(holding_empty_flag),
      .transmitter_idle_flag(transmitter_idle_flag),
      .rx_fifo_error_flag(rx_fifo_error_flag)
   );

   // ------------------------------------------------------------
   // Rate measurement
   // ------------------------------------------------------------
   usa_autobaud #(.CNT_W(CNT_W)) u_autobaud (
      .clk(clk),
      .reset_n(reset_n),
      .ce(ce),
      .rx_line(rx_line),
      .ab(ab.meas),
      .divisor_load(divisor_load),
      .divisor_value(divisor_value)
   );

   // Control bits travel to the counter straight from their flops.
   assign ab.start_req = q.start_req;
   assign ab.stop_req = q.stop_req;
   assign ab.mode = q.mode;
   assign ab.rearm = q.rearm;

   // ------------------------------------------------------------
   // Read views
   // ------------------------------------------------------------
   // The low five status bits belong to the receive path and pass through.
   always_comb begin
      line_status_reg = 8'h00;
      line_status_reg[`USA_LSR_LOW_MSB:0] = lsr_low_bits;
      line_status_reg[`USA_LSR_HOLDING_EMPTY_FLAG] = holding_empty_flag;
      line_status_reg[`USA_LSR_TRANSMITTER_IDLE_FLAG] = transmitter_idle_flag;
      line_status_reg[`USA_LSR_RX_FIFO_ERROR_FLAG] = rx_fifo_error_flag;
   end

   // Start reads as running from the write onward, so software never sees
   // a false finish in the cycle before the counter picks up the request.
   // Reserved and write-only bits read as zero.
   always_comb begin
      acr_view = 32'h0000_0000;
      acr_view[`USA_ACR_START] = ab.busy | q.start_req;
      acr_view[`USA_ACR_MODE] = q.mode;
      acr_view[`USA_ACR_REARM] = q.rearm;
   end

   // ------------------------------------------------------------
   // Register next state
   // ------------------------------------------------------------
   always_comb begin
      next_q = q;
      next_q.start_req = 1'b0;
      next_q.stop_req = 1'b0;

      // Scratch byte: plain storage with no side effect at all.
      if (wr_scr) begin
         next_q.scratch = reg_wdata[7:0];
      end

      // Auto-baud control: a one on start begins a run if none is going,
      // a zero on start while running stops it.
      if (wr_acr) begin
         next_q.mode = reg_wdata[`USA_ACR_MODE];
         next_q.rearm = reg_wdata[`USA_ACR_REARM];
         next_q.start_req = reg_wdata[`USA_ACR_START] & ~ab.busy;
         next_q.stop_req = ~reg_wdata[`USA_ACR_START] & ab.busy;
      end

      // Pending auto-baud interrupts: a new event wins over a clear
      // written in the same cycle, so no event is dropped.
      if (wr_acr && reg_wdata[`USA_ACR_DONE_CLR]) begin
         next_q.done_pend = 1'b0;
      end
      if (ab.done && done_irq_en) begin
         next_q.done_pend = 1'b1;
      end
      if (wr_acr && reg_wdata[`USA_ACR_TO_CLR]) begin
         next_q.to_pend = 1'b0;
      end
      if (ab.timeout && timeout_irq_en) begin
         next_q.to_pend = 1'b1;
      end

      // Read data is registered; unmapped addresses answer zero.
      if (reg_rd) begin
         if (sel_lsr) begin
            next_q.rdata = {24'h00_0000, line_status_reg};
         end else if (sel_scr) begin
            next_q.rdata = {24'h00_0000, q.scratch};
         end else if (sel_acr) begin
            next_q.rdata = acr_view;
         end else begin
            next_q.rdata = 32'h0000_0000;
         end
      end
   end

   // State register; a low clock enable freezes every field.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         q <= '{scratch: `USA_SCR_RST, default: '0};
      end else if (ce) begin
         q <= next_q;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign reg_rdata = q.rdata;
   assign baud_done_irq = q.done_pend;
   assign baud_timeout_irq = q.to_pend;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   scratch_write_a: assert property (ce && wr_scr |=> q.scratch == $past(reg_wdata[7:0]))
      else $error("scratch byte did not take written value");
   scratch_read_a: assert property (ce && reg_rd && sel_scr
      |=> reg_rdata == {24'h00_0000, q.scratch})
      else $error("scratch byte read mismatch");
   scratch_quiet_a: assert property (ce && sel_scr && (reg_wr || reg_rd)
      && !ab.done && !ab.timeout
      |=> $stable(baud_done_irq) && $stable(baud_timeout_irq))
      else $error("scratch access changed an interrupt");
   start_read_a: assert property (ce && reg_rd && sel_acr && ab.busy
      |=> reg_rdata[`USA_ACR_START])
      else $error("start bit reads zero while running");
   start_go_a: assert property (ce && wr_acr && reg_wdata[`USA_ACR_START] && !ab.busy
      ##1 ce |=> ab.busy)
      else $error("measurement not started by start write");
   mode_write_a: assert property (ce && wr_acr |=> ab.mode == $past(reg_wdata[`USA_ACR_MODE]))
      else $error("mode bit not stored");
   done_clear_a: assert property (ce && wr_acr && reg_wdata[`USA_ACR_DONE_CLR] && !ab.done
      |=> !baud_done_irq)
      else $error("done interrupt not cleared");
   done_keep_a: assert property (ce && wr_acr && !reg_wdata[`USA_ACR_DONE_CLR] && baud_done_irq
      |=> baud_done_irq)
      else $error("done interrupt cleared by writing zero");
   to_clear_a: assert property (ce && wr_acr && reg_wdata[`USA_ACR_TO_CLR] && !ab.timeout
      |=> !baud_timeout_irq)
      else $error("time-out interrupt not cleared");
   to_set_a: assert property (ce && ab.timeout && timeout_irq_en |=> baud_timeout_irq)
      else $error("time-out interrupt not raised");

endmodule // usa_status_autobaud

// file: verification/uart_status_autobaud_control_tb_top.sv
// Self-checking testbench of the status, scratch and auto-baud block.
`timescale 1ns/1ps
`include "usa_params.svh"
module uart_status_autobaud_control_tb_top import usa_pkg::*;;
   // --------------------------------------------------
   // Stimulus signals
   // --------------------------------------------------
   logic clk = 1'b0, reset_n = 1'b0, ce = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [31:0] reg_addr = 32'h0, reg_wdata = 32'h0, reg_rdata, rd;
   logic [4:0] lsr_low_bits = 5'h0a;
   logic thr_write = 1'b0, thr_drained = 1'b0, tsr_busy = 1'b0, rx_err_load = 1'b0;
   logic rx_err_pending = 1'b0, fifo_en = 1'b1, done_irq_en = 1'b1, timeout_irq_en = 1'b1;
   logic rx_line, the, tid, rxe, dload, done_irq, to_irq, got;
   logic [4:0] dval, val;
   logic [7:0] seed = 8'h39;
   int fail_count = 0, n_checks = 0, cycles = 0, lo, hi;

   // A small counter width makes the time-out reachable in a few tens of cycles.
   usa_status_autobaud #(.CNT_W(5)) usa_status_autobaud_inst (.clk(clk), .reset_n(reset_n),
      .ce(ce), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .lsr_low_bits(lsr_low_bits), .thr_write(thr_write),
      .thr_drained(thr_drained), .tsr_busy(tsr_busy), .rx_err_load(rx_err_load),
      .rx_err_pending(rx_err_pending), .fifo_en(fifo_en), .rx_line(rx_line),
      .done_irq_en(done_irq_en), .timeout_irq_en(timeout_irq_en), .holding_empty_flag(the),
      .transmitter_idle_flag(tid), .rx_fifo_error_flag(rxe), .divisor_load(dload),
      .divisor_value(dval), .baud_done_irq(done_irq), .baud_timeout_irq(to_irq));
   usa_remote_station usa_remote_station_inst (.clk(clk), .rx_line(rx_line));

   // --------------------------------------------------
   // Clock, watchdog and helpers
   // --------------------------------------------------
   // Half period of the 40 MHz clock.
   always #12.5 clk = ~clk;

   // Cuts a hung run short; the ceiling is well above the few hundred cycles needed.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         wrap_up();
      end
   end

   // Next pseudo-random byte of a Galois shift register.
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], 1'b0} ^ (s[7] ? 8'h1d : 8'h00);
   endfunction

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic reg_write(input logic [31:0] a, input logic [31:0] d);
      @(negedge clk);
      {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
      @(negedge clk);
      reg_wr = 1'b0;
   endtask

   // Read data is taken a cycle and a half after the read edge, where it is settled and held.
   task automatic reg_read(input logic [31:0] a, output logic [31:0] d);
      @(negedge clk);
      {reg_rd, reg_addr} = {1'b1, a};
      @(negedge clk);
      reg_rd = 1'b0;
      @(negedge clk);
      d = reg_rdata;
   endtask

   // Waits a bounded time for a divisor load and keeps its value.
   task automatic wait_load(input int n);
      got = 1'b0;
      while (n > 0 && !got) begin
         @(posedge clk);
         #1;
         if (dload === 1'b1) begin
            got = 1'b1;
            val = dval;
         end
         n--;
      end
   endtask

   task automatic pulse_in(ref logic s);
      @(negedge clk);
      s = 1'b1;
      @(negedge clk);
      s = 1'b0;
      @(negedge clk);
   endtask

   task automatic wrap_up();
      if (fail_count == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // --------------------------------------------------
   // Main sequence
   // --------------------------------------------------
   initial begin
      repeat (5) @(negedge clk);
      reset_n = 1'b1;
      check("flags_rst", {the, tid, rxe}, 3'b110);
      reg_read(`USA_ADDR_SCR, rd);
      check("scr_rst", rd, 32'h0);
      reg_read(`USA_ADDR_ACR, rd);
      check("acr_rst", rd, 32'h0);
      // Scratch traffic changes no flag or interrupt; an unmapped place reads zero.
      repeat (4) begin
         seed = lfsr(seed);
         reg_write(`USA_ADDR_SCR, {24'h0, seed});
         reg_read(`USA_ADDR_SCR, rd);
         check("scr", rd, {24'h0, seed});
         check("scr_side", {the, tid, rxe, done_irq, to_irq}, 5'b11000);
      end
      reg_read(32'he000c018, rd);
      check("unmapped", rd, 32'h0);
      // Holding and shift register flags, with the clock enable held low once.
      ce = 1'b0;
      pulse_in(thr_write);
      check("ce_hold", the, 1'b1);
      ce = 1'b1;
      pulse_in(thr_write);
      check("holding_empty_flag_clr", {the, tid}, 2'b00);
      tsr_busy = 1'b1;
      pulse_in(thr_drained);
      check("holding_empty_flag_set", {the, tid}, 2'b10);
      tsr_busy = 1'b0;
      @(negedge clk);
      @(negedge clk);
      check("transmitter_idle_flag_set", tid, 1'b1);
      // Receive error flag: set, held by a pending error, cleared by a status read.
      pulse_in(rx_err_load);
      rx_err_pending = 1'b1;
      reg_read(`USA_ADDR_LSR, rd);
      check("lsr", rd, {24'h0, 3'b111, 5'h0a});
      rx_err_pending = 1'b0;
      reg_read(`USA_ADDR_LSR, rd);
      check("rx_fifo_error_flag_clr", rxe, 1'b0);
      pulse_in(rx_err_load);
      fifo_en = 1'b0;
      @(negedge clk);
      @(negedge clk);
      check("rx_fifo_error_flag_fifo_off", rxe, 1'b0);
      fifo_en = 1'b1;
      // Measurements in both modes with random pulse lengths.
      for (int i = 0; i < 4; i++) begin
         seed = lfsr(seed);
         lo = 3 + seed % 12;
         hi = 2 + seed[7:4] % 10;
         reg_write(`USA_ADDR_ACR, {30'h0, i[0], 1'b1});
         reg_read(`USA_ADDR_ACR, rd);
         check("acr_run", rd, {30'h0, i[0], 1'b1});
         fork
            begin
               usa_remote_station_inst.pulse(lo, hi);
               if (!i[0]) usa_remote_station_inst.pulse(2, 2);
            end
            wait_load(60);
         join
         // The counter holds one less than the low cycles when it meets the rising
         // edge, and the high phase lasts one cycle more than hi between pulses.
         check("div", {got, val}, {1'b1, 5'(i[0] ? lo - 1 : lo + hi)});
         reg_read(`USA_ADDR_ACR, rd);
         check("acr_end", {rd, done_irq}, {30'h0, i[0], 1'b0, 1'b1});
         reg_write(`USA_ADDR_ACR, 32'h0);
         check("clr0", done_irq, 1'b1);
         reg_write(`USA_ADDR_ACR, 32'h100);
         check("clr1", done_irq, 1'b0);
      end
      // Overflow without rearm ends the run with a time-out and no load.
      reg_write(`USA_ADDR_ACR, 32'h3);
      fork
         usa_remote_station_inst.pulse(40, 3);
         wait_load(45);
      join
      reg_read(`USA_ADDR_ACR, rd);
      check("to_end", rd, 32'h2);
      check("to_flags", {got, to_irq}, 2'b01);
      reg_write(`USA_ADDR_ACR, 32'h200);
      check("to_clr", to_irq, 1'b0);
      // Overflow with rearm waits for the next falling edge and then measures.
      done_irq_en = 1'b0;
      reg_write(`USA_ADDR_ACR, 32'h7);
      usa_remote_station_inst.pulse(40, 3);
      reg_read(`USA_ADDR_ACR, rd);
      check("rearm_run", rd, 32'h7);
      check("rearm_to", to_irq, 1'b1);
      fork
         usa_remote_station_inst.pulse(9, 3);
         wait_load(30);
      join
      check("rearm_div", {got, val, done_irq}, {1'b1, 5'd8, 1'b0});
      reg_write(`USA_ADDR_ACR, 32'h300);
      check("both_clr", {done_irq, to_irq}, 2'b00);
      wrap_up();
   end
endmodule // uart_status_autobaud_control_tb_top

// file: verification/usa_remote_station.sv
// Behavioural model of the remote serial station driving the receive line.
`timescale 1ns/1ps
module usa_remote_station (
   input wire logic clk,
   output logic rx_line
);
   // --------------------------------------------------
   // Line driver
   // --------------------------------------------------
   // The line idles at the marking level, so the block never sees an edge between frames.
   initial begin
      rx_line = 1'b1;
   end

   // One low pulse of lo cycles, then hi cycles high; changes land at the falling clock edge.
   task automatic pulse(input int lo, input int hi);
      @(negedge clk);
      rx_line = 1'b0;
      repeat (lo) @(negedge clk);
      rx_line = 1'b1;
      repeat (hi) @(negedge clk);
   endtask
endmodule // usa_remote_station
